// ===== src/ckoc_pkg.sv
// shared constants and types for the clock output control register bank
package ckoc_pkg;

    // ==================================================================
    // register map and bus constants
    localparam int NUM_REGS = 7;
    localparam logic [6:0] NUM_REGS_IDX = 7'h07;
    localparam logic [6:0] DEV_ADDR = 7'h69;
    localparam logic [7:0] BLOCK_BYTE_COUNT = 8'h07;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] FIRST_TX_BIT = 4'h1;
    localparam logic [6:0] IDX_ZERO = 7'h00;
    localparam logic [6:0] IDX_STEP = 7'h01;
    localparam logic [7:0] READ_FILL = 8'h00;
    localparam int CMD_SINGLE_BIT = 7;

    localparam logic [6:0] REG_DIFF_EN = 7'h00;
    localparam logic [6:0] REG_MISC_EN = 7'h01;
    localparam logic [6:0] REG_PCI_EN = 7'h02;
    localparam logic [6:0] REG_SRC_STOP = 7'h03;
    localparam logic [6:0] REG_FAST_CPU_STOP = 7'h04;
    localparam logic [6:0] REG_DRIVE_MODES = 7'h05;
    localparam logic [6:0] REG_TEST_CTL = 7'h06;

    localparam logic [7:0] REG_RESET [0:NUM_REGS-1] = '{
        8'hFF, 8'hF6, 8'hFF, 8'h00, 8'h07, 8'h00, 8'h18
    };
    // the low three bits of the test byte read back as zero
    localparam logic [7:0] REG_WMASK [0:NUM_REGS-1] = '{
        8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hF8
    };

    // ==================================================================
    // field positions
    localparam int SRC_PAIRS = 6;
    localparam int PAIR7 = 7;
    localparam int CPU_PAIRS = 2;
    localparam int CPU2 = 2;
    localparam int BUS_OUTS = 4;
    localparam int B1_FAST0_EN = 7;
    localparam int B1_DOT_EN = 6;
    localparam int B1_USB_EN = 5;
    localparam int B1_REF_EN = 4;
    localparam int B1_CPU_EN_LO = 1;
    localparam int B1_SPREAD = 0;
    localparam int B2_BUS_EN_LO = 4;
    localparam int B2_HIGH_DRIVE = 3;
    localparam int B2_FAST1_EN = 0;
    localparam int B4_DOT_PD_HIZ = 6;
    localparam int B4_FAST1_STOP = 4;
    localparam int B4_FAST0_STOP = 3;
    localparam int B5_SRC_STOP_HIZ = 7;
    localparam int B5_CPU_STOP_HIZ_LO = 4;
    localparam int B5_SRC_PD_HIZ = 3;
    localparam int B5_CPU_PD_HIZ_LO = 0;
    localparam int B6_REF_DIV = 7;
    localparam int B6_TEST = 6;
    localparam int B6_REF_2X = 4;
    localparam int B6_SW_RUN = 3;

    // ==================================================================
    // types
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_RX = 5'b00010,
        ST_ACK = 5'b00100,
        ST_TX = 5'b01000,
        ST_TX_ACK = 5'b10000
    } ckoc_state_e;

    typedef struct packed {
        logic [7:0] src_run;
        logic [7:0] src_drive;
        logic [1:0] cpu_run;
        logic [1:0] cpu_drive;
        logic dot_run;
        logic dot_drive;
        logic [1:0] fast_run;
        logic [3:0] bus_run;
        logic usb_run;
        logic ref_run;
        logic spread_on;
        logic bus_high_drive;
        logic ref_double_drive;
        logic test_mode;
        logic test_ref_div;
    } ckoc_out_s;

endpackage

// ===== src/ckoc_regs.sv
// clock output control register bank with its two-wire management slave
//
// Operation
// - byte 0 enables source pairs 0-5 and pair 7; 0 tri-states, default 1.
// - byte 1 enables fast bus clock 0, 48 MHz and reference; default 1.
// - byte 1 bit 6 enables the display clock pair; default 1.
// - byte 1 bits 2,1 enable processor pairs 1,0; default 1.
// - byte 1 bit 0 turns spread spectrum on; default off.
// - byte 2 bits 7-4 enable bus clocks 5-2, bit 0 fast clock 1.
// - byte 2 bit 3 selects bus clock high drive; default high.
// - byte 3 bits 7,5-1 let source pairs stop with hardware or software stop.
// - byte 3 bit 0 lets source pair 0 stop with the stop pin only.
// - byte 4 bits 4,3 let fast bus clocks 1,0 stop with bus stop.
// - byte 4 bits 2-0 let processor pairs stop with processor stop; default 1.
// - byte 4 bit 6 tri-states the display pair in power-down.
// - byte 5 bit 7 tri-states stopped source pairs during bus stop.
// - byte 5 bits 6-4 tri-state processor pairs during processor stop.
// - byte 5 bit 3 tri-states source pairs during power-down.
// - byte 5 bits 2-0 tri-state processor pairs during power-down.
// - byte 6 bit 7 picks reference divide (1) or tri-state (0) in test.
// - byte 6 bit 6 enters test mode; bit 7 matters only there.
// - byte 6 bit 3 cleared stops stoppable bus outputs glitch-free.
// - command bit 7 set: single byte at index; clear: block from byte 0.
// - after power-good seen low, the shared pin is a power-down request.
`timescale 1ns/1ps

module ckoc_regs #(
    parameter logic [6:0] SLAVE_ADDR = ckoc_pkg::DEV_ADDR,
    parameter logic [7:0] BLOCK_COUNT = ckoc_pkg::BLOCK_BYTE_COUNT
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe_n,
    input wire logic i_processor_clock_stop_n,
    input wire logic i_bus_clock_stop_n,
    input wire logic i_power_good_strobe_n,
    input wire logic i_pair7_cpu_strap,
    input wire logic i_bus_clk_low_en,
    output ckoc_pkg::ckoc_out_s o_clk_ctl,
    output logic o_power_down_state
);

    // ==================================================================
    // elaboration checks
    if (BLOCK_COUNT == 8'h00) begin : g_bad_count
        $error("block byte count must be non-zero");
    end

    // ==================================================================
    // pin synchronisers
    logic [5:0] pin_meta_r;
    logic [5:0] pin_sync_r;
    logic scl_d_r;
    logic sda_d_r;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pin_meta_r <= 6'h3F;
            pin_sync_r <= 6'h3F;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            pin_meta_r <= {i_scl, i_sda, i_processor_clock_stop_n,
                           i_bus_clock_stop_n, i_power_good_strobe_n,
                           i_pair7_cpu_strap};
            pin_sync_r <= pin_meta_r;
            scl_d_r <= pin_sync_r[5];
            sda_d_r <= pin_sync_r[4];
        end
    end

    wire scl_s = pin_sync_r[5];
    wire sda_s = pin_sync_r[4];
    wire cpu_stop_n_s = pin_sync_r[3];
    wire bus_stop_n_s = pin_sync_r[2];
    wire pgood_s = pin_sync_r[1];
    wire strap_s = pin_sync_r[0];

    wire scl_rise = scl_s & ~scl_d_r;
    wire scl_fall = ~scl_s & scl_d_r;
    wire bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
    wire bus_stop = scl_s & scl_d_r & ~sda_d_r & sda_s;

    // ==================================================================
    // serial slave state
    ckoc_pkg::ckoc_state_e state_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic first_r;
    logic cmd_next_r;
    logic is_read_r;
    logic cnt_pend_r;
    logic ack_ok_r;
    logic sda_low_r;
    logic [6:0] idx_r;
    logic [7:0] regs_r [0:ckoc_pkg::NUM_REGS-1];

    wire byte_done = (state_r == ckoc_pkg::ST_RX) && scl_fall
        && (bit_cnt_r == ckoc_pkg::BITS_PER_BYTE);
    wire addr_hit = (shift_r[7:1] == SLAVE_ADDR);
    wire idx_mapped = (idx_r < ckoc_pkg::NUM_REGS_IDX);
    wire [2:0] idx_sel = idx_r[2:0];
    // a block write's count byte is not stored
    wire reg_we = byte_done & ~first_r & ~cmd_next_r & ~cnt_pend_r
        & idx_mapped;
    wire [7:0] rd_data = idx_mapped ? regs_r[idx_sel]
        : ckoc_pkg::READ_FILL;
    wire [7:0] tx_byte = cnt_pend_r ? BLOCK_COUNT : rd_data;
    wire load_tx = ~bus_start & ~bus_stop & scl_fall
        & (((state_r == ckoc_pkg::ST_ACK) & is_read_r)
        | ((state_r == ckoc_pkg::ST_TX_ACK) & ack_ok_r));

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_r <= ckoc_pkg::ST_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            first_r <= 1'b0;
            cmd_next_r <= 1'b0;
            is_read_r <= 1'b0;
            cnt_pend_r <= 1'b0;
            ack_ok_r <= 1'b0;
            sda_low_r <= 1'b0;
            idx_r <= 7'h00;
        end else if (bus_start) begin
            // a repeated start keeps the index set by the command byte
            state_r <= ckoc_pkg::ST_RX;
            bit_cnt_r <= 4'h0;
            first_r <= 1'b1;
            sda_low_r <= 1'b0;
        end else if (bus_stop) begin
            state_r <= ckoc_pkg::ST_IDLE;
            sda_low_r <= 1'b0;
        end else if (load_tx) begin
            sda_low_r <= ~tx_byte[7];
            shift_r <= {tx_byte[6:0], 1'b0};
            bit_cnt_r <= ckoc_pkg::FIRST_TX_BIT;
            state_r <= ckoc_pkg::ST_TX;
            if (cnt_pend_r) begin
                cnt_pend_r <= 1'b0;
            end else begin
                idx_r <= idx_r + ckoc_pkg::IDX_STEP;
            end
        end else begin
            unique case (state_r)
                ckoc_pkg::ST_IDLE: begin
                    sda_low_r <= 1'b0;
                end
                ckoc_pkg::ST_RX: begin
                    if (scl_rise) begin
                        shift_r <= {shift_r[6:0], sda_s};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end else if (byte_done) begin
                        bit_cnt_r <= 4'h0;
                        first_r <= 1'b0;
                        if (first_r) begin
                            // a foreign address is left unanswered
                            is_read_r <= shift_r[0];
                            cmd_next_r <= ~shift_r[0];
                            sda_low_r <= addr_hit;
                            state_r <= addr_hit ? ckoc_pkg::ST_ACK
                                : ckoc_pkg::ST_IDLE;
                        end else if (cmd_next_r) begin
                            cmd_next_r <= 1'b0;
                            idx_r <= shift_r[ckoc_pkg::CMD_SINGLE_BIT]
                                ? shift_r[6:0] : ckoc_pkg::IDX_ZERO;
                            cnt_pend_r <= ~shift_r[ckoc_pkg::CMD_SINGLE_BIT];
                            sda_low_r <= 1'b1;
                            state_r <= ckoc_pkg::ST_ACK;
                        end else begin
                            if (cnt_pend_r) begin
                                cnt_pend_r <= 1'b0;
                            end else begin
                                idx_r <= idx_r + ckoc_pkg::IDX_STEP;
                            end
                            sda_low_r <= 1'b1;
                            state_r <= ckoc_pkg::ST_ACK;
                        end
                    end
                end
                ckoc_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        sda_low_r <= 1'b0;
                        state_r <= ckoc_pkg::ST_RX;
                    end
                end
                ckoc_pkg::ST_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt_r == ckoc_pkg::BITS_PER_BYTE) begin
                            sda_low_r <= 1'b0;
                            state_r <= ckoc_pkg::ST_TX_ACK;
                        end else begin
                            sda_low_r <= ~shift_r[7];
                            shift_r <= {shift_r[6:0], 1'b0};
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end
                    end
                end
                ckoc_pkg::ST_TX_ACK: begin
                    if (scl_rise) begin
                        ack_ok_r <= ~sda_s;
                    end else if (scl_fall) begin
                        state_r <= ckoc_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ckoc_pkg::ST_IDLE;
                    sda_low_r <= 1'b0;
                end
            endcase
        end
    end

    // open drain: only ever pulls low
    assign o_sda = 1'b0;
    assign o_sda_oe_n = ~sda_low_r;

    // ==================================================================
    // register bank
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            for (int i = 0; i < ckoc_pkg::NUM_REGS; i++) begin
                regs_r[i] <= ckoc_pkg::REG_RESET[i];
            end
        end else if (reg_we) begin
            regs_r[idx_sel] <= shift_r & ckoc_pkg::REG_WMASK[idx_sel];
        end
    end

    wire [7:0] b0 = regs_r[ckoc_pkg::REG_DIFF_EN[2:0]];
    wire [7:0] b1 = regs_r[ckoc_pkg::REG_MISC_EN[2:0]];
    wire [7:0] b2 = regs_r[ckoc_pkg::REG_PCI_EN[2:0]];
    wire [7:0] b3 = regs_r[ckoc_pkg::REG_SRC_STOP[2:0]];
    wire [7:0] b4 = regs_r[ckoc_pkg::REG_FAST_CPU_STOP[2:0]];
    wire [7:0] b5 = regs_r[ckoc_pkg::REG_DRIVE_MODES[2:0]];
    wire [7:0] b6 = regs_r[ckoc_pkg::REG_TEST_CTL[2:0]];

    // ==================================================================
    // power-good strobe, then power-down request
    logic pgood_seen_r;
    logic pair7_cpu_r;
    logic hw_stop_r;
    logic sw_stop_r;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pgood_seen_r <= 1'b0;
            pair7_cpu_r <= 1'b0;
        end else if (~pgood_seen_r & ~pgood_s) begin
            pgood_seen_r <= 1'b1;
            pair7_cpu_r <= strap_s;
        end
    end

    wire power_down = pgood_seen_r & pgood_s;

    // bus stops change only in the low phase of the bus clock: no short pulses
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            hw_stop_r <= 1'b0;
            sw_stop_r <= 1'b0;
        end else if (i_bus_clk_low_en) begin
            hw_stop_r <= ~bus_stop_n_s;
            sw_stop_r <= ~b6[ckoc_pkg::B6_SW_RUN];
        end
    end

    wire bus_stop_any = hw_stop_r | sw_stop_r;
    wire cpu_stop = ~cpu_stop_n_s;

    // {run, drive} of a differential pair
    function automatic logic [1:0] pair_ctl(
        input logic en,
        input logic stop_sel,
        input logic stop,
        input logic stop_hiz,
        input logic pd,
        input logic pd_hiz
    );
        logic halted;
        halted = stop_sel & stop;
        pair_ctl = {en & ~halted & ~pd,
                    en & ~(halted & stop_hiz) & ~(pd & pd_hiz)};
    endfunction

    // ==================================================================
    // output control
    ckoc_pkg::ckoc_out_s ctl_nxt;
    wire test_on = b6[ckoc_pkg::B6_TEST];
    wire ref_div = b6[ckoc_pkg::B6_REF_DIV];

    always_comb begin
        ctl_nxt = '0;
        for (int i = 0; i < ckoc_pkg::SRC_PAIRS; i++) begin
            {ctl_nxt.src_run[i], ctl_nxt.src_drive[i]} = pair_ctl(
                b0[i], b3[i], (i == 0) ? hw_stop_r : bus_stop_any,
                b5[ckoc_pkg::B5_SRC_STOP_HIZ], power_down,
                b5[ckoc_pkg::B5_SRC_PD_HIZ]);
        end
        if (pair7_cpu_r) begin
            {ctl_nxt.src_run[ckoc_pkg::PAIR7],
             ctl_nxt.src_drive[ckoc_pkg::PAIR7]} = pair_ctl(
                b0[ckoc_pkg::PAIR7], b4[ckoc_pkg::CPU2], cpu_stop,
                b5[ckoc_pkg::B5_CPU_STOP_HIZ_LO + ckoc_pkg::CPU2],
                power_down,
                b5[ckoc_pkg::B5_CPU_PD_HIZ_LO + ckoc_pkg::CPU2]);
        end else begin
            {ctl_nxt.src_run[ckoc_pkg::PAIR7],
             ctl_nxt.src_drive[ckoc_pkg::PAIR7]} = pair_ctl(
                b0[ckoc_pkg::PAIR7], b3[ckoc_pkg::PAIR7], bus_stop_any,
                b5[ckoc_pkg::B5_SRC_STOP_HIZ], power_down,
                b5[ckoc_pkg::B5_SRC_PD_HIZ]);
        end
        for (int i = 0; i < ckoc_pkg::CPU_PAIRS; i++) begin
            {ctl_nxt.cpu_run[i], ctl_nxt.cpu_drive[i]} = pair_ctl(
                b1[ckoc_pkg::B1_CPU_EN_LO + i], b4[i], cpu_stop,
                b5[ckoc_pkg::B5_CPU_STOP_HIZ_LO + i], power_down,
                b5[ckoc_pkg::B5_CPU_PD_HIZ_LO + i]);
        end
        {ctl_nxt.dot_run, ctl_nxt.dot_drive} = pair_ctl(
            b1[ckoc_pkg::B1_DOT_EN], 1'b0, 1'b0, 1'b0, power_down,
            b4[ckoc_pkg::B4_DOT_PD_HIZ]);
        ctl_nxt.fast_run[0] = b1[ckoc_pkg::B1_FAST0_EN] & ~power_down
            & ~(b4[ckoc_pkg::B4_FAST0_STOP] & bus_stop_any);
        ctl_nxt.fast_run[1] = b2[ckoc_pkg::B2_FAST1_EN] & ~power_down
            & ~(b4[ckoc_pkg::B4_FAST1_STOP] & bus_stop_any);
        for (int i = 0; i < ckoc_pkg::BUS_OUTS; i++) begin
            ctl_nxt.bus_run[i] = b2[ckoc_pkg::B2_BUS_EN_LO + i]
                & ~power_down & ~bus_stop_any;
        end
        ctl_nxt.usb_run = b1[ckoc_pkg::B1_USB_EN] & ~power_down;
        ctl_nxt.ref_run = b1[ckoc_pkg::B1_REF_EN] & ~power_down;
        ctl_nxt.spread_on = b1[ckoc_pkg::B1_SPREAD];
        ctl_nxt.bus_high_drive = b2[ckoc_pkg::B2_HIGH_DRIVE];
        ctl_nxt.ref_double_drive = b6[ckoc_pkg::B6_REF_2X];
        ctl_nxt.test_mode = test_on;
        ctl_nxt.test_ref_div = test_on & ref_div;
        // test mode: all outputs divided reference or all off
        if (test_on) begin
            ctl_nxt.src_run = {8{ref_div}};
            ctl_nxt.src_drive = {8{ref_div}};
            ctl_nxt.cpu_run = {2{ref_div}};
            ctl_nxt.cpu_drive = {2{ref_div}};
            ctl_nxt.dot_run = ref_div;
            ctl_nxt.dot_drive = ref_div;
            ctl_nxt.fast_run = {2{ref_div}};
            ctl_nxt.bus_run = {4{ref_div}};
            ctl_nxt.usb_run = ref_div;
            ctl_nxt.ref_run = ref_div;
        end
        // there is no pair 6
        ctl_nxt.src_run[ckoc_pkg::SRC_PAIRS] = 1'b0;
        ctl_nxt.src_drive[ckoc_pkg::SRC_PAIRS] = 1'b0;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_clk_ctl <= '0;
            o_power_down_state <= 1'b0;
        end else begin
            o_clk_ctl <= ctl_nxt;
            o_power_down_state <= power_down;
        end
    end

endmodule // ckoc_regs

// ===== testbench/ckoc_checker.sv
// port-level checks for the clock output control register bank
`timescale 1ns/1ps

module ckoc_checker (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_scl,
    input wire logic i_power_good_strobe_n,
    input wire logic o_sda,
    input wire logic o_sda_oe_n,
    input wire ckoc_pkg::ckoc_out_s o_clk_ctl,
    input wire logic o_power_down_state
);
    // ==================================================================
    // relations between the ports
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    sda_value_a: assert property (o_sda == 1'b0)
        else $error("data pin value not held low");
    ack_pull_a: assert property ($fell(o_sda_oe_n) |->
        !i_scl && !$past(i_scl, 2))
        else $error("data pulled outside clock low phase");
    ack_release_a: assert property ($rose(o_sda_oe_n) |->
        !i_scl && !$past(i_scl, 2))
        else $error("data released outside clock low phase");
    sda_stable_a: assert property (i_scl && $past(i_scl) |->
        $stable(o_sda_oe_n))
        else $error("data changed while bus clock high");
    pd_all_off_a: assert property (o_power_down_state &&
        !o_clk_ctl.test_mode |-> o_clk_ctl.src_run == 8'h00 &&
        o_clk_ctl.cpu_run == 2'b00 && !o_clk_ctl.dot_run &&
        o_clk_ctl.bus_run == 4'h0)
        else $error("output running in power-down");
    pd_rise_a: assert property ($rose(o_power_down_state) |->
        $past(i_power_good_strobe_n, 2))
        else $error("power-down without request");
    pd_fall_a: assert property ($fell(o_power_down_state) |->
        !$past(i_power_good_strobe_n, 2))
        else $error("power-down left while requested");
    test_override_a: assert property (o_clk_ctl.test_mode |->
        o_clk_ctl.cpu_run == {2{o_clk_ctl.test_ref_div}} &&
        o_clk_ctl.dot_run == o_clk_ctl.test_ref_div)
        else $error("test mode not overriding outputs");
    reserved_pair_a: assert property (!o_clk_ctl.src_run[6] &&
        !o_clk_ctl.src_drive[6])
        else $error("reserved source slot active");
endmodule // ckoc_checker

bind ckoc_regs ckoc_checker u_ckoc_checker (.i_clk, .i_rst, .i_scl,
    .i_power_good_strobe_n, .o_sda, .o_sda_oe_n, .o_clk_ctl,
    .o_power_down_state);

// ===== testbench/ckoc_host.sv
// management bus host model: bus clock and open-drain data, 1 releases
`timescale 1ns/1ps

module ckoc_host (
    input wire logic i_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda
);
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    // repeated start enters with the clock low, so one task serves both
    task automatic start();
        o_sda <= 1'b1;
        wait_clk(6);
        o_scl <= 1'b1;
        wait_clk(12);
        o_sda <= 1'b0;
        wait_clk(12);
        o_scl <= 1'b0;
        wait_clk(6);
    endtask

    task automatic stop();
        o_sda <= 1'b0;
        wait_clk(6);
        o_scl <= 1'b1;
        wait_clk(12);
        o_sda <= 1'b1;
        wait_clk(12);
    endtask

    // eight bits and the ninth; a released bit reads back the slave
    task automatic xfer(input logic [7:0] d, input logic rel9,
                        output logic [7:0] q, output logic ack);
        logic [8:0] s;
        logic [8:0] r;
        s = {d, rel9};
        r = 9'h000;
        for (int i = 8; i >= 0; i--) begin
            o_sda <= s[i];
            wait_clk(6);
            o_scl <= 1'b1;
            wait_clk(6);
            r = {r[7:0], i_sda};
            wait_clk(6);
            o_scl <= 1'b0;
            wait_clk(6);
        end
        q = r[8:1];
        ack = !r[0];
    endtask
endmodule // ckoc_host

// ===== testbench/tb_ckoc_regs.sv
// self-checking bench for the clock output control register bank
`timescale 1ns/1ps

module tb_ckoc_regs;
    localparam logic [7:0] AW = {ckoc_pkg::DEV_ADDR, 1'b0};
    localparam logic [7:0] AR = {ckoc_pkg::DEV_ADDR, 1'b1};
    localparam logic [7:0] RST [7] = '{8'hFF, 8'hF6, 8'hFF, 8'h00, 8'h07,
        8'h00, 8'h18};
    localparam logic [7:0] BLK [7] = '{8'hFF, 8'hF6, 8'hFF, 8'h03, 8'h07,
        8'h80, 8'h18};
    logic i_clk;
    logic i_rst;
    logic scl;
    logic sda_h;
    wire logic sda_line;
    logic cpu_stop_n;
    logic bus_stop_n;
    logic pgood_n;
    logic strap;
    logic low_en;
    logic sda_v;
    logic oe_n;
    logic pd;
    ckoc_pkg::ckoc_out_s c;
    int failures = 0;
    int check_count = 0;
    int cycles = 0;
    logic [7:0] q;
    logic a;

    // pull-up
    assign sda_line = sda_h & (oe_n | sda_v);

    ckoc_host u_ckoc_host (.i_clk(i_clk), .i_sda(sda_line), .o_scl(scl),
        .o_sda(sda_h));
    ckoc_regs u_ckoc_regs (.i_clk(i_clk), .i_rst(i_rst), .i_scl(scl),
        .i_sda(sda_line), .o_sda(sda_v), .o_sda_oe_n(oe_n),
        .i_processor_clock_stop_n(cpu_stop_n),
        .i_bus_clock_stop_n(bus_stop_n), .i_power_good_strobe_n(pgood_n),
        .i_pair7_cpu_strap(strap), .i_bus_clk_low_en(low_en),
        .o_clk_ctl(c), .o_power_down_state(pd));

    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        low_en <= (cycles[1:0] == 2'b00);
        if (cycles == 60000) begin
            failures++;
            $display("[FAIL] %0t run too long", $time);
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            failures++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    // writes keep reserved bits at their default values
    task automatic xb(input logic [7:0] d, input logic rel = 1'b1);
        u_ckoc_host.xfer(d, rel, q, a);
    endtask

    task automatic wr(input logic [6:0] idx, input logic [7:0] d);
        logic ok;
        u_ckoc_host.start();
        xb(AW);
        ok = a;
        xb({1'b1, idx});
        ok &= a;
        xb(d);
        ok &= a;
        u_ckoc_host.stop();
        chk(ok, "write not acknowledged");
        u_ckoc_host.wait_clk(4);
    endtask

    task automatic rd(input logic [6:0] idx, output logic [7:0] d);
        u_ckoc_host.start();
        xb(AW);
        xb({1'b1, idx});
        u_ckoc_host.start();
        xb(AR);
        xb(8'hFF);
        u_ckoc_host.stop();
        d = q;
    endtask

    task automatic do_reset(input logic s);
        strap <= s;
        cpu_stop_n <= 1'b1;
        bus_stop_n <= 1'b1;
        pgood_n <= 1'b1;
        i_rst <= 1'b1;
        repeat (16) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        pgood_n <= 1'b0;
        repeat (8) @(posedge i_clk);
    endtask

    task automatic t_defaults();
        for (int i = 0; i < 7; i++) begin
            rd(i[6:0], q);
            chk(q === RST[i], "reset value");
        end
        chk({c.src_run, c.src_drive} === 16'hBFBF, "src");
        chk({c.cpu_run, c.dot_run, c.usb_run, c.ref_run, c.spread_on,
            c.ref_double_drive} === 7'h7D, "misc");
        chk({c.bus_run, c.fast_run, c.bus_high_drive,
            c.test_mode} === 8'hFE, "bus");
        $display("test defaults done");
    endtask

    task automatic t_enables();
        wr(7'h01, 8'h01);
        chk({c.spread_on, c.cpu_run, c.dot_run, c.dot_drive, c.cpu_drive}
            === 7'h40, "b1");
        chk({c.usb_run, c.ref_run, c.fast_run[0]} === 3'h0, "b1 misc");
        wr(7'h02, 8'h06);
        chk({c.bus_run, c.bus_high_drive, c.fast_run[1]} === 6'h00, "b2");
        wr(7'h00, 8'h40);
        chk({c.src_run, c.src_drive} === 16'h0000, "b0");
        $display("test enables done");
    endtask

    task automatic t_block();
        u_ckoc_host.start();
        xb(AW);
        xb(8'h00);
        xb(8'h07);
        for (int i = 0; i < 7; i++) xb(BLK[i]);
        u_ckoc_host.stop();
        u_ckoc_host.start();
        xb(AW);
        xb(8'h00);
        u_ckoc_host.start();
        xb(AR);
        xb(8'hFF, 1'b0);
        chk(q === 8'h07, "block count");
        for (int i = 0; i < 7; i++) begin
            xb(8'hFF, i == 6);
            chk(q === BLK[i], "block byte");
        end
        u_ckoc_host.stop();
        chk({c.src_run, c.bus_run} === 12'hBFF, "restored");
        $display("test block done");
    endtask

    task automatic t_refuse();
        wr(7'h07, 8'h5A);
        rd(7'h07, q);
        chk(q === 8'h00, "unmapped read");
        u_ckoc_host.start();
        xb(8'hA4);
        u_ckoc_host.stop();
        chk(a === 1'b0, "foreign address acknowledged");
        $display("test refuse done");
    endtask

    task automatic t_stops();
        wr(7'h04, 8'h0F);
        bus_stop_n <= 1'b0;
        u_ckoc_host.wait_clk(20);
        chk({c.src_run, c.src_drive} === 16'hBCBC, "src stop");
        chk({c.bus_run, c.fast_run} === 6'h02, "fast stop");
        bus_stop_n <= 1'b1;
        cpu_stop_n <= 1'b0;
        u_ckoc_host.wait_clk(20);
        chk({c.src_run, c.cpu_run, c.cpu_drive}
            === 12'hBF3, "cpu stop");
        wr(7'h05, 8'h90);
        chk(c.cpu_drive === 2'b10, "cpu stop hiz");
        cpu_stop_n <= 1'b1;
        u_ckoc_host.wait_clk(20);
        chk({c.cpu_run, c.cpu_drive} === 4'hF, "cpu run");
        wr(7'h04, 8'h07);
        wr(7'h06, 8'h10);
        chk({c.src_run, c.bus_run, c.fast_run}
            === 14'h2F43, "soft stop");
        wr(7'h06, 8'h18);
        chk({c.src_run, c.bus_run} === 12'hBFF, "soft run");
        $display("test stops done");
    endtask

    task automatic t_pd();
        wr(7'h05, 8'h89);
        wr(7'h04, 8'h47);
        pgood_n <= 1'b1;
        u_ckoc_host.wait_clk(20);
        chk({pd, c.src_run, c.cpu_run} === 11'h400, "power-down");
        chk({c.src_drive, c.cpu_drive, c.dot_drive}
            === 11'h004, "pd drive");
        pgood_n <= 1'b0;
        u_ckoc_host.wait_clk(20);
        chk({pd, c.src_run, c.dot_drive}
            === 10'h17F, "pd left");
        $display("test power-down done");
    endtask

    task automatic t_test();
        wr(7'h06, 8'hD8);
        chk({c.test_mode, c.test_ref_div} === 2'h3, "div");
        wr(7'h06, 8'h58);
        chk({c.test_mode, c.test_ref_div} === 2'h2, "hi-z");
        wr(7'h06, 8'h98);
        chk({c.test_mode, c.cpu_run} === 3'h3, "normal");
        wr(7'h06, 8'h18);
        $display("test mode done");
    endtask

    // pair 7 strapped as processor pair 2 follows the processor stop
    task automatic t_strap();
        cpu_stop_n <= 1'b0;
        u_ckoc_host.wait_clk(20);
        chk({c.src_run, c.src_drive} === 16'h3FBF, "pair 7 cpu");
        cpu_stop_n <= 1'b1;
        $display("test strap done");
    endtask

    initial begin
        do_reset(1'b0);
        t_defaults();
        t_enables();
        t_block();
        t_refuse();
        t_stops();
        t_pd();
        t_test();
        do_reset(1'b1);
        t_strap();
        wrap_up();
    end
endmodule // tb_ckoc_regs
